// [include/ulsx_pkg.sv]
package ulsx_pkg;
  // Core-side addresses of the indirect access pair
  localparam logic [5:0] ULSX_EXT_INDEX_ADDR = 6'h20;
  localparam logic [5:0] ULSX_EXT_DATA_ADDR = 6'h21;
  // Extension register indices
  localparam logic [7:0] ULSX_IDX_RX_BUFFER = 8'h00;
  localparam logic [7:0] ULSX_IDX_TX_HOLDING = 8'h01;
  localparam logic [7:0] ULSX_IDX_LINE_STATUS = 8'h06;
  // Line status layout
  localparam int ULSX_LS_DR = 0;
  localparam int ULSX_LS_OE = 1;
  localparam int ULSX_LS_PE = 2;
  localparam int ULSX_LS_FE = 3;
  localparam int ULSX_LS_BI = 4;
  localparam int ULSX_LS_TX_HOLDING_EMPTY = 5;
  localparam int ULSX_LS_TX_ALL_EMPTY = 6;
  localparam logic [7:0] ULSX_LS_RESET = 8'h60;
  // Oversampling timing in 16x ticks, word lengths in bits, tick shift and shifter width
  localparam logic [3:0] ULSX_TICK_HALF = 4'h7;
  localparam logic [3:0] ULSX_TICK_LAST = 4'hf;
  localparam logic [3:0] ULSX_WLEN_BASE = 4'h5;
  localparam logic [3:0] ULSX_DATA_MAX = 4'h8;
  localparam logic [8:0] ULSX_STOP1_TICKS = 9'h010;
  localparam logic [8:0] ULSX_STOP15_TICKS = 9'h018;
  localparam logic [8:0] ULSX_STOP2_TICKS = 9'h020;
  localparam int ULSX_TICK_SHIFT = 4;
  localparam int ULSX_TX_W = 12;

  // Line control fields as supplied by the configuration block
  typedef struct packed {
    logic brge;
    logic sb;
    logic sp;
    logic eps;
    logic pen;
    logic stb;
    logic [1:0] wls;
  } ulsx_lcr_t;

  typedef enum logic [4:0] {
    ULSX_RX_IDLE = 5'h01,
    ULSX_RX_START = 5'h02,
    ULSX_RX_DATA = 5'h04,
    ULSX_RX_PAR = 5'h08,
    ULSX_RX_STOP = 5'h10
  } ulsx_rx_st_t;
endpackage : ulsx_pkg

// [verilog/ulsx_line_status.sv]
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1 - Data-ready is set while the receive buffer holds data, cleared when read.
// R2 - Frames with line errors still load data bits and set data-ready.
// R3 - New character before buffer read sets overrun; old data lost, data-ready stays.
// R4 - Parity fault only when parity enabled and parity bit mismatches expectation.
// R5 - Even expects one on odd count of ones; odd expects one on even.
// R6 - Stick parity one expects one; stick parity zero expects zero.
// R7 - Framing judged only at centre of first stop bit; high means good.
// R8 - Break set once input low longer than one frame, not at rising edge.
// R9 - A cleared break is not set again during the same low period.
// R10 - Setting break also sets framing fault.
// R11 - Holding-empty is one whenever the holding register has no byte.
// R12 - All-empty set when holding empty and the shifter has finished.
// R13 - Reading line status clears overrun, parity, framing and break flags.
// R14 - Option one routes serial in/out to port pins 1/0, else GPIO.
// R15 - Core reaches registers only through index and data registers; hardware times access.
// R16 - Software reads by writing index then reading data register.
// R17 - Software writes by writing index then writing data register.
// R18 - Line status read also clears the pending line-error interrupt source.
// R19 - Read returns pre-read flags; clearing lands on the next cycle.
// R20 - Bit 7 reads zero; writes to line status are ignored.
module ulsx_line_status
  import ulsx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire ulsx_lcr_t lcr_cfg,
  input wire logic baud_tick16,
  input wire logic uart_pin_option,
  input wire logic [1:0] port_d_in,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  output logic [1:0] port_d_out,
  output logic [1:0] port_d_oe,
  input wire logic [7:0] ext_rdata,
  output logic [7:0] ext_index,
  output logic [7:0] ext_wdata,
  output logic ext_wr_stb,
  output logic ext_rd_stb,
  output logic [7:0] line_status,
  output logic line_err_pend
);

  // Expected parity bit for the given data and format
  function automatic logic ulsx_par_exp(input ulsx_lcr_t c, input logic [7:0] d);
    logic ones;
    ones = ^d;
    if (c.sp) ulsx_par_exp = ~c.eps; // see R6
    else ulsx_par_exp = c.eps ? ones : ~ones; // see R5
  endfunction : ulsx_par_exp

  // Whole frame length in 16x ticks
  function automatic logic [8:0] ulsx_frame_ticks(input ulsx_lcr_t c);
    logic [8:0] bits;
    logic [8:0] stop;
    bits = 9'(ULSX_WLEN_BASE + {2'h0, c.wls} + {3'h0, c.pen} + 4'h1);
    if (!c.stb) stop = ULSX_STOP1_TICKS;
    else if (c.wls == 2'h0) stop = ULSX_STOP15_TICKS;
    else stop = ULSX_STOP2_TICKS;
    ulsx_frame_ticks = 9'(bits << ULSX_TICK_SHIFT) + stop;
  endfunction : ulsx_frame_ticks

  ulsx_rx_st_t rx_st_r;
  logic [3:0] rx_cnt_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_par_r;
  logic sin_prev_r;
  logic [7:0] rx_buffer_r;
  logic dr_r, oe_r, pe_r, fe_r, bi_r;
  logic [8:0] brk_cnt_r;
  logic brk_armed_r;
  logic [7:0] tx_holding_r;
  logic thr_full_r;
  logic tx_busy_r;
  logic [ULSX_TX_W-1:0] tx_shift_reg_r;
  logic [8:0] tx_cnt_r;
  logic [8:0] tx_ft_r;
  logic [7:0] ext_index_r;
  logic serial_in, serial_out;
  logic [3:0] wlen;
  logic [7:0] mask, rx_data, tx_data;
  logic [8:0] frame_ticks;
  logic dat_rd, dat_wr, lsr_rd, rbr_rd, thr_wr, own_idx;
  logic rx_load, oe_ev, pe_ev, fe_ev, brk_ev, tx_load;
  logic [ULSX_TX_W-1:0] tx_frame;

  // Pin muxing; idle-high input when the port stays GPIO
  assign serial_in = uart_pin_option ? port_d_in[1] : 1'b1; // see R14
  assign serial_out = lcr_cfg.sb ? 1'b0 : (tx_busy_r ? tx_shift_reg_r[0] : 1'b1);

  // Access decode of the indirect pair
  assign dat_rd = cpu_rd && (cpu_addr == ULSX_EXT_DATA_ADDR); // see R16
  assign dat_wr = cpu_wr && (cpu_addr == ULSX_EXT_DATA_ADDR); // see R17
  assign lsr_rd = dat_rd && (ext_index_r == ULSX_IDX_LINE_STATUS);
  assign rbr_rd = dat_rd && (ext_index_r == ULSX_IDX_RX_BUFFER);
  assign thr_wr = dat_wr && (ext_index_r == ULSX_IDX_TX_HOLDING);
  assign own_idx = (ext_index_r == ULSX_IDX_RX_BUFFER) ||
                   (ext_index_r == ULSX_IDX_TX_HOLDING) ||
                   (ext_index_r == ULSX_IDX_LINE_STATUS);

  // Format-dependent widths
  assign wlen = ULSX_WLEN_BASE + {2'h0, lcr_cfg.wls};
  assign mask = 8'(9'h0ff >> (ULSX_DATA_MAX - wlen));
  assign frame_ticks = ulsx_frame_ticks(lcr_cfg);
  assign rx_data = 8'(rx_sh_r >> (ULSX_DATA_MAX - wlen));
  assign tx_data = tx_holding_r & mask;

  // Receive events; stop sample alone judges framing
  assign rx_load = (rx_st_r == ULSX_RX_STOP) && baud_tick16 && (rx_cnt_r == ULSX_TICK_LAST);
  assign oe_ev = rx_load && dr_r && !rbr_rd; // see R3
  assign pe_ev = rx_load && lcr_cfg.pen && (rx_par_r != ulsx_par_exp(lcr_cfg, rx_data)); // see R4
  assign fe_ev = rx_load && !serial_in; // see R7
  assign brk_ev = baud_tick16 && !serial_in && brk_armed_r && (brk_cnt_r == frame_ticks); // see R8

  // Receiver sequencer, 16x oversampled, starts on a falling edge only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= ULSX_RX_IDLE;
      rx_cnt_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
      sin_prev_r <= 1'b1;
    end else begin
      sin_prev_r <= serial_in;
      unique case (rx_st_r)
        ULSX_RX_IDLE: begin
          if (!serial_in && sin_prev_r) begin
            rx_st_r <= ULSX_RX_START;
            rx_cnt_r <= 4'h0;
          end
        end
        ULSX_RX_START: begin
          if (baud_tick16) begin
            if (rx_cnt_r == ULSX_TICK_HALF) begin
              // Glitch shorter than half a bit is not a start
              rx_st_r <= serial_in ? ULSX_RX_IDLE : ULSX_RX_DATA;
              rx_cnt_r <= 4'h0;
              rx_bit_r <= 3'h0;
            end else begin
              rx_cnt_r <= rx_cnt_r + 4'h1;
            end
          end
        end
        ULSX_RX_DATA: begin
          if (baud_tick16) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == ULSX_TICK_LAST) begin
              rx_sh_r <= {serial_in, rx_sh_r[7:1]};
              rx_bit_r <= rx_bit_r + 3'h1;
              if (rx_bit_r == 3'(wlen - 4'h1)) begin
                rx_st_r <= lcr_cfg.pen ? ULSX_RX_PAR : ULSX_RX_STOP;
              end
            end
          end
        end
        ULSX_RX_PAR: begin
          if (baud_tick16) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == ULSX_TICK_LAST) begin
              rx_par_r <= serial_in;
              rx_st_r <= ULSX_RX_STOP;
            end
          end
        end
        ULSX_RX_STOP: begin
          if (baud_tick16) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == ULSX_TICK_LAST) rx_st_r <= ULSX_RX_IDLE;
          end
        end
        default: rx_st_r <= ULSX_RX_IDLE;
      endcase
    end
  end

  // Low-time counter for break; rearmed only by a high level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      brk_cnt_r <= 9'h000;
      brk_armed_r <= 1'b1;
    end else if (serial_in) begin
      brk_cnt_r <= 9'h000;
      brk_armed_r <= 1'b1;
    end else if (brk_ev) begin
      brk_armed_r <= 1'b0; // see R9
    end else if (baud_tick16 && brk_cnt_r != frame_ticks) begin
      brk_cnt_r <= brk_cnt_r + 9'h001;
    end
  end

  // Receive buffer and data-ready; a load wins over a read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buffer_r <= 8'h00;
      dr_r <= 1'b0;
    end else if (rx_load) begin
      rx_buffer_r <= rx_data; // see R2
      dr_r <= 1'b1; // see R1
    end else if (rbr_rd) begin
      dr_r <= 1'b0; // see R1
    end
  end

  // Error flags: set wins over the clearing read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oe_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      bi_r <= 1'b0;
      line_err_pend <= 1'b0;
    end else begin
      oe_r <= oe_ev | (oe_r & ~lsr_rd); // see R13
      pe_r <= pe_ev | (pe_r & ~lsr_rd); // see R13
      fe_r <= fe_ev | brk_ev | (fe_r & ~lsr_rd); // see R10
      bi_r <= brk_ev | (bi_r & ~lsr_rd); // see R13
      line_err_pend <= oe_ev | pe_ev | fe_ev | brk_ev | (line_err_pend & ~lsr_rd); // see R18
    end
  end

  // Holding register; a new write while loading keeps it full
  assign tx_load = thr_full_r && !tx_busy_r;
  assign tx_frame = ({ULSX_TX_W{1'b1}} << (wlen + {3'h0, lcr_cfg.pen} + 4'h1)) |
                    (ULSX_TX_W'({lcr_cfg.pen & ulsx_par_exp(lcr_cfg, tx_data)}) << (wlen + 4'h1)) |
                    ULSX_TX_W'({tx_data, 1'b0});
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_r <= 8'h00;
      thr_full_r <= 1'b0;
    end else if (thr_wr) begin
      tx_holding_r <= cpu_wdata;
      thr_full_r <= 1'b1;
    end else if (tx_load) begin
      thr_full_r <= 1'b0; // see R11
    end
  end

  // Shifter; busy until the whole frame with stop time has left
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_r <= 1'b0;
      tx_shift_reg_r <= {ULSX_TX_W{1'b1}};
      tx_cnt_r <= 9'h000;
      tx_ft_r <= 9'h000;
    end else if (tx_load) begin
      tx_busy_r <= 1'b1;
      tx_shift_reg_r <= tx_frame;
      tx_cnt_r <= 9'h000;
      tx_ft_r <= frame_ticks;
    end else if (tx_busy_r && baud_tick16) begin
      tx_cnt_r <= tx_cnt_r + 9'h001;
      if (tx_cnt_r[3:0] == ULSX_TICK_LAST) tx_shift_reg_r <= {1'b1, tx_shift_reg_r[ULSX_TX_W-1:1]};
      if (tx_cnt_r == tx_ft_r - 9'h001) tx_busy_r <= 1'b0; // see R12
    end
  end

  // Status image; bit 7 fixed at zero, no write path exists
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_status <= ULSX_LS_RESET;
    end else begin
      line_status <= 8'h00; // see R20
      line_status[ULSX_LS_DR] <= rx_load | (dr_r & ~rbr_rd);
      line_status[ULSX_LS_OE] <= oe_ev | (oe_r & ~lsr_rd);
      line_status[ULSX_LS_PE] <= pe_ev | (pe_r & ~lsr_rd);
      line_status[ULSX_LS_FE] <= fe_ev | brk_ev | (fe_r & ~lsr_rd);
      line_status[ULSX_LS_BI] <= brk_ev | (bi_r & ~lsr_rd);
      line_status[ULSX_LS_TX_HOLDING_EMPTY] <= !(thr_wr || (thr_full_r && !tx_load)); // see R11
      line_status[ULSX_LS_TX_ALL_EMPTY] <= !thr_wr && !thr_full_r && !tx_load &&
        !(tx_busy_r && !(baud_tick16 && tx_cnt_r == tx_ft_r - 9'h001)); // see R12
    end
  end

  // Registered pins; UART drives bit 0, bit 1 is input only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_d_out <= 2'h0;
      port_d_oe <= 2'h0;
    end else if (uart_pin_option) begin
      port_d_out <= {1'b0, serial_out}; // see R14
      port_d_oe <= 2'h1;
    end else begin
      port_d_out <= gpio_out;
      port_d_oe <= gpio_oe;
    end
  end

  // Indirect access; strobes to the other registers made here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_index_r <= 8'h00;
      cpu_rdata <= 8'h00;
      ext_wdata <= 8'h00;
      ext_wr_stb <= 1'b0;
      ext_rd_stb <= 1'b0;
    end else begin
      if (cpu_wr && cpu_addr == ULSX_EXT_INDEX_ADDR) ext_index_r <= cpu_wdata;
      if (dat_wr) ext_wdata <= cpu_wdata;
      ext_wr_stb <= dat_wr && !own_idx; // see R15
      ext_rd_stb <= dat_rd && !own_idx; // see R15
      if (cpu_rd && cpu_addr == ULSX_EXT_INDEX_ADDR) cpu_rdata <= ext_index_r;
      else if (rbr_rd) cpu_rdata <= rx_buffer_r;
      else if (lsr_rd) cpu_rdata <= line_status; // see R19
      else if (dat_rd) cpu_rdata <= ext_rdata;
    end
  end
  assign ext_index = ext_index_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_dr_on_load: assert property (rx_load |=> line_status[ULSX_LS_DR] && dr_r) // see R1
    else $error("data ready not set by load");
  a_dr_clear: assert property (rbr_rd && !rx_load |=> !dr_r) // see R1
    else $error("data ready not cleared by buffer read");
  a_ovr_set: assert property (rx_load && dr_r && !rbr_rd |=> oe_r && dr_r) // see R3
    else $error("overrun missed");
  a_par_off: assert property (rx_load && !lcr_cfg.pen && !pe_r |=> !pe_r) // see R4
    else $error("parity fault with parity off");
  a_brk_frame: assert property ($rose(bi_r) |-> fe_r) // see R10
    else $error("break without framing fault");
  a_brk_once: assert property (!bi_r && !brk_armed_r && !serial_in |=> !bi_r) // see R9
    else $error("break set twice in one low period");
  a_err_clear: assert property (lsr_rd && !rx_load && !brk_ev |=> !(oe_r|pe_r|fe_r|bi_r)) // see R13
    else $error("error flags survive status read");
  a_rd_before: assert property (lsr_rd |=> cpu_rdata == $past(line_status)) // see R19
    else $error("status read not pre-clear value");
  a_bit7_zero: assert property (line_status[7] == 1'b0) // see R20
    else $error("status bit 7 set");
  a_tx_all_empty_tx_holding_empty: assert property (line_status[ULSX_LS_TX_ALL_EMPTY] |-> line_status[ULSX_LS_TX_HOLDING_EMPTY]) // see R12
    else $error("all empty without holding empty");
  a_pin_route: assert property (uart_pin_option |=> port_d_oe == 2'h1) // see R14
    else $error("port pins not routed");
  a_fwd_write: assert property (dat_wr && !own_idx |=> ext_wr_stb ##1 !ext_wr_stb) // see R15
    else $error("forward strobe wrong");
  c_frame: cover property (rx_load ##[1:200] rbr_rd);
  c_break: cover property ($rose(bi_r) ##[1:300] lsr_rd);
  c_overrun: cover property (oe_ev);
  c_tx_done: cover property ($rose(line_status[ULSX_LS_TX_ALL_EMPTY]));
endmodule : ulsx_line_status
`default_nettype wire

// [verification/ulsx_peer_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ulsx_peer_model (
  input wire logic mclk,
  input wire logic tick,
  input wire logic dut_tx,
  output logic line
);
  logic [7:0] rx_byte;
  int rx_cnt;

  // Line rests at mark level between frames
  initial begin
    line = 1'b1;
    rx_cnt = 0;
    rx_byte = 8'h00;
  end

  task automatic wait_ticks(input int n);
    repeat (n) @(posedge mclk iff tick);
  endtask : wait_ticks

  task automatic set_line(input logic v);
    @(posedge mclk);
    line <= v;
  endtask : set_line

  // LSB first; bad parity or a low stop only when a scenario asks
  task automatic send_frame(input logic [7:0] d, input int nb, input logic pen,
                            input logic par, input logic stop);
    set_line(1'b0);
    wait_ticks(16);
    for (int i = 0; i < nb; i++) begin
      line <= d[i];
      wait_ticks(16);
    end
    if (pen) begin
      line <= par;
      wait_ticks(16);
    end
    line <= stop;
    wait_ticks(16);
    line <= 1'b1;
    wait_ticks(32);
  endtask : send_frame

  // Centre sampling of 8-bit frames, no parity
  always begin
    @(negedge dut_tx);
    wait_ticks(8);
    for (int i = 0; i < 8; i++) begin
      wait_ticks(16);
      rx_byte[i] = dut_tx;
    end
    wait_ticks(16);
    rx_cnt++;
  end
endmodule : ulsx_peer_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ulsx_pkg::*;
  logic mclk = 1'b0;
  logic rst_n, cpu_wr, cpu_rd, baud_tick16, uart_pin_option, ext_wr_stb, ext_rd_stb;
  logic line_err_pend, peer_line;
  logic [5:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, ext_rdata, ext_index, ext_wdata, line_status;
  logic [1:0] gpio_out, gpio_oe, port_d_out, port_d_oe, tdiv;
  ulsx_lcr_t lcr_cfg;
  int error_cnt, tests_run;

  ulsx_line_status uut (.mclk(mclk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .lcr_cfg(lcr_cfg),
    .baud_tick16(baud_tick16), .uart_pin_option(uart_pin_option),
    .port_d_in({peer_line, port_d_out[0]}), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .port_d_out(port_d_out), .port_d_oe(port_d_oe), .ext_rdata(ext_rdata),
    .ext_index(ext_index), .ext_wdata(ext_wdata), .ext_wr_stb(ext_wr_stb),
    .ext_rd_stb(ext_rd_stb), .line_status(line_status), .line_err_pend(line_err_pend));

  ulsx_peer_model peer (.mclk(mclk), .tick(baud_tick16), .dut_tx(port_d_out[0]),
    .line(peer_line));

  always #12.5 mclk = ~mclk;

  // Short divisor keeps the run brief; no ticks while reset holds
  always @(posedge mclk) begin
    if (!rst_n) begin
      tdiv <= 2'h0;
      baud_tick16 <= 1'b0;
    end else begin
      tdiv <= tdiv + 2'h1;
      baud_tick16 <= (tdiv == 2'h3);
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cpu_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge mclk);
    cpu_wr <= 1'b0;
  endtask : cpu_write

  task automatic cpu_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge mclk);
    cpu_rd <= 1'b0;
    #1 d = cpu_rdata;
  endtask : cpu_read

  task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
    cpu_write(ULSX_EXT_INDEX_ADDR, idx);
    cpu_write(ULSX_EXT_DATA_ADDR, d);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] idx, output logic [7:0] d);
    cpu_write(ULSX_EXT_INDEX_ADDR, idx);
    cpu_read(ULSX_EXT_DATA_ADDR, d);
  endtask : reg_read

  task automatic set_lcr(input logic sp, input logic eps, input logic pen,
                         input logic [1:0] wls);
    @(posedge mclk);
    lcr_cfg <= '{1'b1, 1'b0, sp, eps, pen, 1'b0, wls};
  endtask : set_lcr

  // Every parity mode, right and wrong parity bit
  task automatic t_parity();
    logic [7:0] d, got;
    logic p;
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < 2; b++) begin
        d = 8'h5a + 8'(m * 3 + b);
        case (m)
          0: p = ~^d;
          1: p = ^d;
          2: p = 1'b1;
          default: p = 1'b0;
        endcase
        set_lcr(m[1], m[0], 1'b1, 2'b11);
        peer.send_frame(d, 8, 1'b1, p ^ b[0], 1'b1);
        reg_read(ULSX_IDX_LINE_STATUS, got);
        chk("parity status", 8'h61 | {5'h00, b[0], 2'b00}, got);
        chk("status after read", 8'h61, line_status);
        reg_read(ULSX_IDX_RX_BUFFER, got);
        chk("rx data", d, got);
        chk("data ready clear", 8'h60, line_status);
      end
    end
  endtask : t_parity

  // Short word with a low stop bit
  task automatic t_framing();
    logic [7:0] got;
    set_lcr(1'b0, 1'b0, 1'b0, 2'b00);
    peer.send_frame(8'h13, 5, 1'b0, 1'b0, 1'b0);
    chk("line err pending", 8'h01, {7'h00, line_err_pend});
    reg_read(ULSX_IDX_LINE_STATUS, got);
    chk("framing status", 8'h69, got);
    chk("line err cleared", 8'h00, {7'h00, line_err_pend});
    reg_read(ULSX_IDX_RX_BUFFER, got);
    chk("framed data", 8'h13, got);
  endtask : t_framing

  task automatic t_overrun();
    logic [7:0] got;
    set_lcr(1'b0, 1'b0, 1'b0, 2'b11);
    peer.send_frame(8'h11, 8, 1'b0, 1'b0, 1'b1);
    peer.send_frame(8'h22, 8, 1'b0, 1'b0, 1'b1);
    reg_read(ULSX_IDX_LINE_STATUS, got);
    chk("overrun status", 8'h63, got);
    reg_read(ULSX_IDX_RX_BUFFER, got);
    chk("newest data kept", 8'h22, got);
  endtask : t_overrun

  // Two stop bits make the frame 176 ticks; break must outlast it
  task automatic t_break();
    logic [7:0] got;
    @(posedge mclk);
    lcr_cfg <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'b11};
    peer.set_line(1'b0);
    peer.wait_ticks(100);
    #1 chk("no break early", 8'h60, line_status);
    peer.wait_ticks(70);
    #1 chk("framing before break", 8'h69, line_status);
    peer.wait_ticks(10);
    #1 chk("break status", 8'h79, line_status);
    reg_read(ULSX_IDX_LINE_STATUS, got);
    chk("break read", 8'h79, got);
    chk("break cleared", 8'h61, line_status);
    peer.wait_ticks(200);
    chk("no second break", 8'h61, line_status);
    peer.set_line(1'b1);
    peer.wait_ticks(32);
    reg_read(ULSX_IDX_RX_BUFFER, got);
    chk("break data", 8'h00, got);
  endtask : t_break

  task automatic t_tx();
    int c0, n;
    c0 = peer.rx_cnt;
    reg_write(ULSX_IDX_TX_HOLDING, 8'hc3);
    repeat (4) @(posedge mclk);
    #1 chk("shifter busy", 8'h20, line_status & 8'h60);
    n = 0;
    while (line_status[6] !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("all empty", 8'h60, line_status);
    chk("frames seen", 8'h01, 8'(peer.rx_cnt - c0));
    chk("tx byte", 8'hc3, peer.rx_byte);
  endtask : t_tx

  task automatic t_ext();
    logic [7:0] got;
    reg_write(8'h03, 8'h18);
    #1 chk("wr strobe", 8'h01, {7'h00, ext_wr_stb});
    chk("wr data", 8'h18, ext_wdata);
    chk("wr index", 8'h03, ext_index);
    @(posedge mclk);
    ext_rdata <= 8'hc6;
    #1 chk("wr strobe end", 8'h00, {7'h00, ext_wr_stb});
    reg_read(8'h02, got);
    chk("fwd read", 8'hc6, got);
    chk("rd strobe", 8'h01, {7'h00, ext_rd_stb});
    reg_write(ULSX_IDX_LINE_STATUS, 8'hff);
    #1 chk("status write ignored", 8'h60, line_status);
    chk("no strobe", 8'h00, {7'h00, ext_wr_stb});
    cpu_write(6'h22, 8'h44);
    #1 chk("unmapped ignored", ULSX_IDX_LINE_STATUS, ext_index);
  endtask : t_ext

  // General-purpose mode must cut the receiver off too
  task automatic t_pins();
    // Break transmit forces the serial output pin low
    @(posedge mclk);
    lcr_cfg.sb <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk("break out", 8'h00, {6'h00, port_d_out});
    @(posedge mclk);
    lcr_cfg.sb <= 1'b0;
    uart_pin_option <= 1'b0;
    gpio_out <= 2'b10;
    gpio_oe <= 2'b11;
    repeat (3) @(posedge mclk);
    #1 chk("gpio out", 8'h02, {6'h00, port_d_out});
    chk("gpio oe", 8'h03, {6'h00, port_d_oe});
    peer.send_frame(8'h0f, 8, 1'b0, 1'b0, 1'b1);
    chk("no rx in gpio", 8'h60, line_status);
  endtask : t_pins

  task automatic final_report();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    {cpu_wr, cpu_rd} = 2'h0;
    cpu_addr = 6'h00;
    cpu_wdata = 8'h00;
    lcr_cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11};
    uart_pin_option = 1'b1;
    gpio_out = 2'b00;
    gpio_oe = 2'b00;
    ext_rdata = 8'h5a;
    error_cnt = 0;
    tests_run = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk("reset status", ULSX_LS_RESET, line_status);
    chk("uart oe", 8'h01, {6'h00, port_d_oe});
    peer.wait_ticks(16);
    t_parity();
    t_framing();
    t_overrun();
    t_break();
    t_tx();
    t_ext();
    t_pins();
    final_report();
  end
endmodule : testbench
`default_nettype wire
